// ### common/timed_serdes_io_defs.svh
// offsets, field positions, reset values and counts for the timed serdes io port
`ifndef TIMED_SERDES_IO_DEFS_SVH
`define TIMED_SERDES_IO_DEFS_SVH
`define OFF_CTRL 8'h00
`define OFF_DATA 8'h04
`define OFF_COUNT 8'h08
`define OFF_TIME 8'h0C
`define OFF_STAMP 8'h10
`define OFF_COND 8'h14
`define OFF_STATUS 8'h18
`define OFF_CLKCFG 8'h20
`define CLKCFG_IDX_LSB 2
`define CLKCFG_IDX_W 3
`define NUM_CLK_BLOCKS 6
`define REF_CLK_BLOCK 3'h0
`define COUNTER_W 16
`define WORD_W 32
`define CTRL_W 11
`define CTRL_RESET 11'h000
`define CLKCFG_W 17
`define CLKCFG_RESET 17'h00000
`define ST_TR_FULL 0
`define ST_SHIFT_BUSY 1
`define ST_TIME_ARMED 2
`define ST_COND_ARMED 3
`define ST_EVENT 4
`define REF_FREQ_MHZ 100
`define HCLK_FREQ_MHZ 20
`endif

// ### common/timed_serdes_io_pkg.sv
// types shared by the timed serdes io port
package timed_serdes_io_pkg;
  // port control word, lsb is enable
  typedef struct packed {
    logic [2:0] clk_sel;
    logic strobe_out_en;
    logic strobe_in_en;
    logic cond_not_equal;
    logic cond_en;
    logic buffered;
    logic open_collector;
    logic dir_out;
    logic enable;
  } ctrl_s;
  // clock block setting: source and divide ratio
  typedef struct packed {
    logic src_pin;
    logic [15:0] divide;
  } clkcfg_s;
  typedef enum logic {XS_IDLE, XS_SHIFT} xfer_state_e;
endpackage

// ### core/timed_serdes_io_port.sv
// timed serdes io port with six clock blocks and an ahb-lite register slave
// Summary of operation
// [R1] port width is a parameter limited to 1, 4, 8, 16 or 32 bits
// [R2] one direction bit sets the whole port as input or output
// [R3] port drives pins or samples them, optionally waiting for a pin condition
// [R4] every register access completes with no wait state, except blocked data
// [R5] open collector drives low for zero and releases pins for one, port wide
// [R6] data passes through a shift stage and a transfer register
// [R7] a 16-bit port counter paces transfers between pins and transfer register
// [R8] counter readable anytime; a programmed time delays the next transfer
// [R9] each transfer saves the counter value as a readable timestamp
// [R10] enabled link on shared pins disables port pin drive
// [R11] an enabled narrower port takes shared pins from this port
// [R12] pins not claimed by a narrower port stay with this port
// [R13] the port always transfers at its full nominal width
// [R14] six clock blocks: block 0 is reference, others programmable dividers
// [R15] a clock block may run from a synchronised pin, optionally divided
// [R16] strobe input qualifies sampling; strobe output accompanies output data
// [R17] after reset the port uses clock block 0
// [R18] pin conditions and words raise a direct event pulse, no interrupt; here received words and input condition matches do, sent words raise none
// [R19] counter steps once per clock block tick and wraps to zero
// [R20] buffered read stalls until word is full; write stalls while occupied
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "timed_serdes_io_defs.svh"
module timed_serdes_io_port #(
  parameter int PORT_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe_n,
  input wire logic link_enable,
  input wire logic [PORT_W-1:0] narrow_claim,
  input wire logic clk_src_pin,
  input wire logic strobe_in,
  output logic strobe_out,
  output logic event_pulse,
  output timed_serdes_io_pkg::xfer_state_e xfer_state
);
  import timed_serdes_io_pkg::*;

  localparam int WORDS = `WORD_W / PORT_W;
  localparam int SYNC_W = PORT_W + 2;
  // reference block ticks every hclk; its nominal rate is a label only
  localparam int REF_TICKS_PER_HCLK = `HCLK_FREQ_MHZ / `HCLK_FREQ_MHZ;

  initial begin
    if (!(PORT_W == 1 || PORT_W == 4 || PORT_W == 8 || PORT_W == 16 || PORT_W == 32)) begin
      $error("unsupported port width"); // R1
    end
  end

  ctrl_s ctrl_r;
  clkcfg_s clkcfg_r [`NUM_CLK_BLOCKS];
  logic ap_valid_r;
  logic ap_write_r;
  logic [7:0] ap_addr_r;
  logic [SYNC_W-1:0] sync1_r, sync2_r, sync3_r, stable_r;
  logic src_prev_r;
  logic [`NUM_CLK_BLOCKS-1:0] cb_tick;
  logic [`COUNTER_W-1:0] counter_r, time_r, stamp_r;
  logic time_armed_r, cond_armed_r, event_r;
  logic [PORT_W-1:0] cond_r, pin_val_r;
  logic [31:0] tr_r, shift_r;
  logic tr_full_r;
  logic [5:0] shift_cnt_r;
  logic strobe_r, event_pulse_r;

  // ---------------- bus slave ----------------
  logic blocked, do_wr, do_rd, ap_take;
  logic [PORT_W-1:0] pins_s;
  logic src_s, strobe_s;
  assign pins_s = stable_r[PORT_W-1:0] & ~narrow_claim;
  assign src_s = stable_r[PORT_W];
  assign strobe_s = stable_r[PORT_W+1];

  assign ap_take = hsel & htrans[1] & hready;
  always_comb begin
    blocked = 1'b0;
    if (ap_valid_r && ap_addr_r == `OFF_DATA && ctrl_r.enable) begin
      blocked = ap_write_r ? (ctrl_r.dir_out & tr_full_r) : (~ctrl_r.dir_out & ~tr_full_r); // R20
    end
  end
  assign hreadyout = ~blocked; // R4
  assign hresp = 1'b0;
  assign do_wr = ap_valid_r & ap_write_r & ~blocked;
  assign do_rd = ap_valid_r & ~ap_write_r & ~blocked;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else if (hreadyout) begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite;
      ap_addr_r <= haddr[7:0];
    end
  end

  // read mux of registered state; an unmapped address reads zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (ap_valid_r && !ap_write_r) begin
      unique case (ap_addr_r)
        `OFF_CTRL: hrdata = {{(32-`CTRL_W){1'b0}}, ctrl_r};
        `OFF_DATA: hrdata = ctrl_r.dir_out ? 32'h0000_0000 : tr_r;
        `OFF_COUNT: hrdata = {16'h0000, counter_r}; // R8
        `OFF_TIME: hrdata = {16'h0000, time_r};
        `OFF_STAMP: hrdata = {16'h0000, stamp_r}; // R9
        `OFF_COND: hrdata = 32'(cond_r);
        `OFF_STATUS: hrdata = {27'h0000000, event_r, cond_armed_r, time_armed_r, (shift_cnt_r != 6'h00), tr_full_r};
        default: begin
          if (ap_addr_r[7:5] == `OFF_CLKCFG >> 5 && ap_addr_r[4:2] < 3'(`NUM_CLK_BLOCKS)) begin
            hrdata = {{(32-`CLKCFG_W){1'b0}}, clkcfg_r[ap_addr_r[4:2]]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `CTRL_RESET; // R17
    end else if (do_wr && ap_addr_r == `OFF_CTRL) begin
      ctrl_r <= hwdata[`CTRL_W-1:0]; // R2
    end
  end

  // ---------------- input synchronisers ----------------
  // a level is taken once the second and third stages agree, filtering one-cycle glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      stable_r <= '0;
      src_prev_r <= 1'b0;
    end else begin
      sync1_r <= {strobe_in, clk_src_pin, pin_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int b = 0; b < SYNC_W; b++) begin
        if (sync2_r[b] == sync3_r[b]) begin
          stable_r[b] <= sync3_r[b];
        end
      end
      src_prev_r <= src_s;
    end
  end

  // ---------------- clock blocks ----------------
  logic src_rise;
  assign src_rise = src_s & ~src_prev_r;
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CLK_BLOCKS; gi++) begin : g_cb
      if (gi == 0) begin : g_ref
        assign cb_tick[gi] = REF_TICKS_PER_HCLK == 1; // R14
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            clkcfg_r[gi] <= `CLKCFG_RESET;
          end
        end
      end else begin : g_div
        logic [15:0] div_cnt_r;
        logic src_edge;
        assign src_edge = clkcfg_r[gi].src_pin ? src_rise : 1'b1; // R15
        assign cb_tick[gi] = src_edge & (div_cnt_r == clkcfg_r[gi].divide);
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            clkcfg_r[gi] <= `CLKCFG_RESET;
          end else if (do_wr && ap_addr_r[7:5] == `OFF_CLKCFG >> 5 && ap_addr_r[4:2] == 3'(gi)) begin
            clkcfg_r[gi] <= hwdata[`CLKCFG_W-1:0]; // R14
          end
        end
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            div_cnt_r <= 16'h0000;
          end else if (cb_tick[gi]) begin
            div_cnt_r <= 16'h0000;
          end else if (src_edge) begin
            div_cnt_r <= div_cnt_r + 16'h0001; // R15
          end
        end
      end
    end
  endgenerate

  // ---------------- port timing ----------------
  logic tick, time_ok, cond_hit, sample_ok, out_go, in_go, in_done;
  logic [5:0] words_eff;
  logic [PORT_W+31:0] in_cat;
  logic [31:0] in_next;
  assign tick = ctrl_r.enable & ((ctrl_r.clk_sel < 3'(`NUM_CLK_BLOCKS)) ? cb_tick[ctrl_r.clk_sel] : cb_tick[`REF_CLK_BLOCK]);
  assign time_ok = ~time_armed_r | (counter_r == time_r); // R8
  assign cond_hit = ctrl_r.cond_not_equal ? (pins_s != cond_r) : (pins_s == cond_r); // R3
  assign words_eff = ctrl_r.buffered ? 6'(WORDS) : 6'h01; // R6
  assign sample_ok = (~ctrl_r.strobe_in_en | strobe_s) & (~cond_armed_r | cond_hit) & time_ok; // R16
  assign in_go = tick & ~ctrl_r.dir_out & ~tr_full_r & sample_ok;
  assign in_done = in_go & (shift_cnt_r == words_eff - 6'h01);
  assign out_go = tick & ctrl_r.dir_out & (shift_cnt_r == 6'h00) & tr_full_r & time_ok;
  assign in_cat = {pins_s, shift_r} >> PORT_W;
  assign in_next = ctrl_r.buffered ? in_cat[31:0] : 32'(pins_s); // R13
  assign xfer_state = (shift_cnt_r != 6'h00) ? XS_SHIFT : XS_IDLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_r <= 16'h0000;
    end else if (tick) begin
      // R7
      counter_r <= counter_r + 16'h0001; // R19
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_r <= 16'h0000;
      time_armed_r <= 1'b0;
    end else if (do_wr && ap_addr_r == `OFF_TIME) begin
      time_r <= hwdata[15:0];
      time_armed_r <= 1'b1; // R8
    end else if (out_go || in_done) begin
      time_armed_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_r <= '0;
      cond_armed_r <= 1'b0;
    end else if (do_wr && ap_addr_r == `OFF_COND) begin
      cond_r <= hwdata[PORT_W-1:0];
      cond_armed_r <= ctrl_r.cond_en; // R3
    end else if (in_go && cond_armed_r) begin
      cond_armed_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stamp_r <= 16'h0000;
    end else if (out_go || in_done) begin
      stamp_r <= counter_r; // R9
    end
  end

  // ---------------- serdes and transfer register ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tr_r <= 32'h0000_0000;
      tr_full_r <= 1'b0;
    end else if (do_wr && ap_addr_r == `OFF_DATA && ctrl_r.dir_out) begin
      tr_r <= hwdata; // R6
      tr_full_r <= 1'b1;
    end else if (do_rd && ap_addr_r == `OFF_DATA && !ctrl_r.dir_out && tr_full_r) begin
      tr_full_r <= 1'b0; // R20
    end else if (out_go) begin
      tr_full_r <= 1'b0;
    end else if (in_done) begin
      tr_r <= in_next;
      tr_full_r <= 1'b1; // R20
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r <= 32'h0000_0000;
      shift_cnt_r <= 6'h00;
      pin_val_r <= '0;
      strobe_r <= 1'b0;
    end else if (!ctrl_r.enable) begin
      shift_cnt_r <= 6'h00;
      strobe_r <= 1'b0;
    end else if (ctrl_r.dir_out) begin
      if (tick && shift_cnt_r != 6'h00) begin
        pin_val_r <= shift_r[PORT_W-1:0];
        shift_r <= shift_r >> PORT_W; // R13
        shift_cnt_r <= shift_cnt_r - 6'h01;
        strobe_r <= ctrl_r.strobe_out_en; // R16
      end else if (out_go) begin
        pin_val_r <= tr_r[PORT_W-1:0]; // R3
        shift_r <= tr_r >> PORT_W;
        shift_cnt_r <= words_eff - 6'h01;
        strobe_r <= ctrl_r.strobe_out_en;
      end else if (tick) begin
        strobe_r <= 1'b0;
      end
    end else if (in_go) begin
      shift_r <= in_cat[31:0]; // R6
      shift_cnt_r <= in_done ? 6'h00 : shift_cnt_r + 6'h01;
      strobe_r <= 1'b0;
    end
  end

  // ---------------- events ----------------
  // set wins over a same-cycle write-one clear
  logic ev_set;
  assign ev_set = in_done | (in_go & cond_armed_r);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_r <= 1'b0;
      event_pulse_r <= 1'b0;
    end else begin
      event_pulse_r <= ev_set; // R18
      if (ev_set) begin
        event_r <= 1'b1;
      end else if (do_wr && ap_addr_r == `OFF_STATUS && hwdata[`ST_EVENT]) begin
        event_r <= 1'b0;
      end
    end
  end
  assign event_pulse = event_pulse_r;
  assign strobe_out = strobe_r;

  // ---------------- pin drive ----------------
  logic [PORT_W-1:0] own;
  assign own = {PORT_W{ctrl_r.enable & ctrl_r.dir_out & ~link_enable}} & ~narrow_claim; // R10 R11 R12
  assign pin_out = ctrl_r.open_collector ? '0 : pin_val_r;
  assign pin_oe_n = ~(own & (ctrl_r.open_collector ? ~pin_val_r : {PORT_W{1'b1}})); // R5
endmodule

// ### bench/timed_serdes_io_port_properties.sv
// concurrent checks on the timed serdes io port pins and bus
`timescale 1ns/1ps
`include "timed_serdes_io_defs.svh"
module timed_serdes_io_port_properties #(
  parameter int PORT_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe_n,
  input wire logic link_enable,
  input wire logic [PORT_W-1:0] narrow_claim,
  input wire logic strobe_out,
  input wire logic event_pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // only a data phase of the DATA register may ever insert wait states
  logic data_phase_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) data_phase_r <= 1'h0;
    else if (hready) data_phase_r <= hsel && htrans[1] && haddr[7:0] == `OFF_DATA;
  end
  a_resp_okay: assert property (hresp == 1'h0)
    else $error("response not okay");
  a_idle_ready: assert property (!data_phase_r |-> hreadyout)
    else $error("wait state outside data access");
  a_nowait_reg: assert property (hsel && htrans[1] && hready && haddr[7:0] != `OFF_DATA |=> hreadyout)
    else $error("register access stalled");
  a_link_release: assert property (link_enable |-> &pin_oe_n)
    else $error("pins driven while link enabled");
  a_claim_release: assert property ((narrow_claim & ~pin_oe_n) == '0)
    else $error("claimed pin still driven");
  // a partly driven port must be open collector, so driven pins are low
  a_oc_drive: assert property (((~pin_oe_n & ~narrow_claim) != ~narrow_claim) && (~pin_oe_n != '0)
    |-> (pin_out & ~pin_oe_n) == '0)
    else $error("partial drive not low");
  a_pulse_single: assert property (event_pulse |=> !event_pulse)
    else $error("event pulse too long");
  a_reset_quiet: assert property ($rose(hresetn) |-> hreadyout && !strobe_out && !event_pulse && &pin_oe_n)
    else $error("outputs active after reset");
endmodule

// ### bench/pin_partner.sv
// external pin hardware: drives inputs, resolves the wires, captures strobed output
`timescale 1ns/1ps
module pin_partner #(
  parameter int PORT_W = 8
) (
  input wire logic hclk,
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe_n,
  input wire logic strobe_out,
  input wire logic [PORT_W-1:0] ext_val,
  output logic [PORT_W-1:0] pin_in,
  output logic strobe_in,
  output logic clk_src_pin,
  output logic [31:0] cap
);
  // a released pin shows what the outside drives, a driven pin the port value
  assign pin_in = (pin_oe_n & ext_val) | (~pin_oe_n & pin_out);
  initial begin
    strobe_in = 1'h0;
    clk_src_pin = 1'h0;
    cap = 32'h0;
  end
  always @(posedge hclk) begin
    strobe_in <= ~strobe_in;
    clk_src_pin <= ~clk_src_pin;
    if (strobe_out === 1'h1) cap <= {pin_out, cap[31:PORT_W]};
  end
endmodule

// ### bench/timed_serdes_io_port_bench.sv
// self-checking bench for the timed serdes io port
`timescale 1ns/1ps
`include "timed_serdes_io_defs.svh"
module timed_serdes_io_port_bench;
  import timed_serdes_io_pkg::*;
  localparam int PORT_W = 8;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, link_enable = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, d, c;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [PORT_W-1:0] narrow_claim = '0, ext_val = '0;
  logic hreadyout, hresp, clk_src_pin, strobe_in, strobe_out, event_pulse;
  logic [31:0] hrdata, cap;
  logic [PORT_W-1:0] pin_in, pin_out, pin_oe_n;
  xfer_state_e xfer_state;
  integer seed = 38, fails = 0, checks_done = 0, m;
  timed_serdes_io_port #(.PORT_W(PORT_W)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .link_enable(link_enable), .narrow_claim(narrow_claim), .clk_src_pin(clk_src_pin),
    .strobe_in(strobe_in), .strobe_out(strobe_out), .event_pulse(event_pulse), .xfer_state(xfer_state));
  pin_partner #(.PORT_W(PORT_W)) i_partner (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .strobe_out(strobe_out), .ext_val(ext_val), .pin_in(pin_in), .strobe_in(strobe_in),
    .clk_src_pin(clk_src_pin), .cap(cap));
  initial begin
    forever #25 hclk = ~hclk;
  end
  function automatic logic [PORT_W-1:0] exp_oe(input logic oc, input logic [PORT_W-1:0] v, cl,
    input logic ln);
    exp_oe = ln ? '1 : ((oc ? v : '0) | cl);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h7;
    while (s[2:0] !== 3'h0) bus(1'h0, `OFF_STATUS, 32'h0, s);
    @(negedge hclk);
  endtask
  task automatic end_of_test;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h0, `OFF_CTRL, 32'h0, r); chk(r, 32'h0);
    bus(1'h0, `OFF_CLKCFG, 32'h0, r); chk(r, 32'h0);
    bus(1'h0, 8'h1C, 32'h0, r); chk(r, 32'h0);
    d = $random(seed);
    bus(1'h1, 8'h24, d, r);
    bus(1'h0, 8'h24, 32'h0, r); chk(r, d & 32'h1FFFF);
    for (m = 0; m < 2; m++) begin
      bus(1'h1, `OFF_CTRL, m ? 32'h7 : 32'h3, r);
      d = $random(seed);
      bus(1'h1, `OFF_DATA, d, r);
      wait_idle;
      chk(32'(pin_oe_n), 32'(exp_oe(m[0], d[PORT_W-1:0], '0, 1'h0)));
      chk(32'(pin_out), m ? 32'h0 : 32'(d[PORT_W-1:0]));
    end
    narrow_claim <= $random(seed);
    @(negedge hclk);
    chk(32'(pin_oe_n), 32'(exp_oe(1'h1, d[PORT_W-1:0], narrow_claim, 1'h0)));
    @(posedge hclk);
    link_enable <= 1'h1;
    @(negedge hclk);
    chk(32'(pin_oe_n), 32'(exp_oe(1'h0, '0, '0, 1'h1)));
    @(posedge hclk);
    link_enable <= 1'h0;
    narrow_claim <= '0;
    bus(1'h1, `OFF_CTRL, 32'h3, r);
    bus(1'h0, `OFF_COUNT, 32'h0, c);
    bus(1'h1, `OFF_TIME, c + 32'h28, r);
    bus(1'h1, `OFF_DATA, $random(seed), r);
    wait_idle;
    bus(1'h0, `OFF_STAMP, 32'h0, r); chk(r, (c + 32'h28) & 32'hFFFF);
    // second write lands in the transfer register while the first word is still shifting out
    bus(1'h1, `OFF_CTRL, 32'h8B, r);
    bus(1'h1, `OFF_DATA, $random(seed), r);
    bus(1'h1, `OFF_DATA, $random(seed), r);
    chk(32'(xfer_state), 32'(XS_SHIFT));
    wait_idle;
    d = $random(seed);
    bus(1'h1, `OFF_DATA, d, r);
    wait_idle;
    chk(cap, d);
    ext_val <= $random(seed);
    bus(1'h1, `OFF_CTRL, 32'h0, r);
    bus(1'h0, `OFF_STATUS, 32'h0, r);
    bus(1'h0, `OFF_STATUS, 32'h0, r);
    bus(1'h1, `OFF_CTRL, 32'h9, r);
    bus(1'h0, `OFF_DATA, 32'h0, r); chk(r, {4{ext_val}});
    chk(32'(event_pulse), 32'h1);
    bus(1'h0, `OFF_STATUS, 32'h0, r); chk(32'(r[`ST_EVENT]), 32'h1);
    end_of_test;
  end
endmodule
bind timed_serdes_io_port timed_serdes_io_port_properties #(.PORT_W(PORT_W)) i_props (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .link_enable(link_enable),
  .narrow_claim(narrow_claim), .strobe_out(strobe_out), .event_pulse(event_pulse));
